// file: rtl/pfbo_pkg.sv
/*
  Constants, register layout and carrier types for the fault B override
  control block. Assumes a 32-bit AHB-Lite register bus on hclk.
*/
// Contract
// - override value bits force outputs active or inactive
// - mode bit one selects cycle-by-cycle handling
// - mode bit zero latches outputs to override value bits
// - pair enable bits select pairs under override
// - bits 15-14 and 6-3 read zero
// - lock set needs key sequence before write
// - lock clear allows writes at any time
// - enables reset to one, others to zero
package pfbo_pkg;
  localparam logic [7:0]  PFBO_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  PFBO_KEY_OFS    = 8'h04;
  localparam logic [7:0]  PFBO_STAT_OFS   = 8'h08;
  localparam logic [7:0]  PFBO_CLR_OFS    = 8'h0C;
  localparam int          PFBO_OV_LSB     = 8;
  localparam int          PFBO_MODE_BIT   = 7;
  localparam logic [15:0] PFBO_CTRL_WMASK = 16'h3F87;
  localparam logic [15:0] PFBO_CTRL_RST   = 16'h0007;
  localparam logic [15:0] PFBO_KEY_FIRST  = 16'hABCD;
  localparam logic [15:0] PFBO_KEY_SECOND = 16'h4321;

  typedef enum logic [1:0] {
    PFBO_LOCKED,
    PFBO_KEY1_OK,
    PFBO_OPEN
  } pfbo_key_e;

  typedef struct packed {
    logic [5:0] ov;
    logic       mode;
    logic [2:0] en;
  } pfbo_ctrl_s;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } pfbo_pins_s;
endpackage

// file: rtl/pfbo_top.sv
/*
  Fault B override control: AHB-Lite register slave, write lock with
  two-word key, latched or cycle-by-cycle override of three pin pairs.
  Assumes fault_b and the lock strap come from pins; period_end and the
  PWM pin values come from the time base on hclk.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pfbo_top
  import pfbo_pkg::*;
(
  input  wire logic        hclk,        // 200 MHz clock
  input  wire logic        hresetn,     // Async reset, active low
  input  wire logic        hsel,        // Slave select
  input  wire logic [31:0] haddr,       // Byte address
  input  wire logic [1:0]  htrans,      // Transfer type
  input  wire logic        hwrite,      // Write when high
  input  wire logic [2:0]  hsize,       // Transfer size
  input  wire logic [31:0] hwdata,      // Write data
  input  wire logic        hready,      // Bus ready
  output logic      [31:0] hrdata,      // Read data
  output logic             hreadyout,   // Always ready
  output logic             hresp,       // Always OKAY
  input  wire logic        lock_pin,    // Write lock strap
  input  wire logic        fault_b_pin, // Fault B, active high
  input  wire logic        period_end,  // PWM period boundary pulse
  input  wire pfbo_pins_s  pwm_in,      // Generated PWM levels
  output pfbo_pins_s       pwm_out      // Pin levels after override
);

  // Pin synchronisers
  logic [1:0]  flt_sync_r;
  logic [1:0]  flt_sync_nxt;
  logic [1:0]  lck_sync_r;
  logic [1:0]  lck_sync_nxt;

  // Bus address phase capture and read data
  logic        ap_wr_r;
  logic        ap_wr_nxt;
  logic [7:0]  ap_ofs_r;
  logic [7:0]  ap_ofs_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] rd_nxt;

  // Control register and key state
  pfbo_ctrl_s  ctrl_r;
  pfbo_ctrl_s  ctrl_nxt;
  pfbo_key_e   key_r;
  pfbo_key_e   key_nxt;

  // Override state
  logic        act_r;
  logic        act_nxt;

  // Decoded strobes and register views
  logic        addr_ph;
  logic        rd_req;
  logic        key_wr;
  logic        ctrl_wr;
  logic        clr_req;
  logic        oth_wr;
  logic        wr_ok;
  logic        fault_b;
  logic        wlock;
  logic        key_open;
  logic [5:0]  fv;
  logic [15:0] ctrl_word;
  logic [31:0] stat_word;
  pfbo_ctrl_s  ctrl_wval;

  assign fault_b   = flt_sync_r[1];
  assign wlock     = lck_sync_r[1];
  assign key_open  = (key_r == PFBO_OPEN);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Unused bits stay zero by construction
  assign ctrl_word = {2'h0, ctrl_r.ov, ctrl_r.mode, 4'h0, ctrl_r.en};
  assign stat_word = {28'h000_0000, key_open, wlock, fault_b, act_r};

  // Only the second flop feeds logic
  always_comb begin
    flt_sync_nxt = {flt_sync_r[0], fault_b_pin};
    lck_sync_nxt = {lck_sync_r[0], lock_pin};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_sync_r <= 2'h0;
      lck_sync_r <= 2'h0;
    end else begin
      flt_sync_r <= flt_sync_nxt;
      lck_sync_r <= lck_sync_nxt;
    end
  end

  // Zero wait states: every address phase is taken at once
  assign addr_ph = hsel & hready & htrans[1];
  assign rd_req  = addr_ph & ~hwrite;

  always_comb begin
    ap_wr_nxt  = addr_ph & hwrite;
    ap_ofs_nxt = ap_ofs_r;
    rd_nxt     = hrdata_r;
    if (addr_ph) begin
      ap_ofs_nxt = haddr[7:0];
    end
    if (rd_req) begin
      unique case (haddr[7:0])
        PFBO_CTRL_OFS: rd_nxt = {16'h0000, ctrl_word};
        PFBO_STAT_OFS: rd_nxt = stat_word;
        default:       rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r  <= 1'b0;
      ap_ofs_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      ap_wr_r  <= ap_wr_nxt;
      ap_ofs_r <= ap_ofs_nxt;
      hrdata_r <= rd_nxt;
    end
  end

  // Writes are taken in the data phase, while hwdata stands
  assign key_wr    = ap_wr_r & (ap_ofs_r == PFBO_KEY_OFS);
  assign ctrl_wr   = ap_wr_r & (ap_ofs_r == PFBO_CTRL_OFS);
  assign clr_req   = ap_wr_r & (ap_ofs_r == PFBO_CLR_OFS) & hwdata[0];
  assign oth_wr    = ap_wr_r & ~key_wr;
  assign wr_ok     = ~wlock | key_open;
  assign ctrl_wval = pfbo_ctrl_s'({hwdata[13:7], hwdata[2:0]}
                     & {PFBO_CTRL_WMASK[13:7], PFBO_CTRL_WMASK[2:0]});

  always_comb begin
    key_nxt = key_r;
    if (key_wr) begin
      if (hwdata[15:0] == PFBO_KEY_FIRST) begin
        key_nxt = PFBO_KEY1_OK;
      end else if (key_r == PFBO_KEY1_OK &&
                   hwdata[15:0] == PFBO_KEY_SECOND) begin
        key_nxt = PFBO_OPEN;
      end else begin
        key_nxt = PFBO_LOCKED;
      end
    end else if (oth_wr) begin
      // Key opens for one write only, so a stray write cannot reuse it
      key_nxt = PFBO_LOCKED;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_r <= PFBO_LOCKED;
    end else begin
      key_r <= key_nxt;
    end
  end

  // A refused write is dropped silently; the bus still answers OKAY
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (ctrl_wr && wr_ok) begin
      ctrl_nxt = ctrl_wval;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= pfbo_ctrl_s'({PFBO_CTRL_RST[13:7],
                              PFBO_CTRL_RST[2:0]});
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Override state; a new fault beats a clear in the same cycle
  always_comb begin
    act_nxt = act_r;
    if (fault_b) begin
      act_nxt = 1'b1;
    end else if (ctrl_r.mode) begin
      if (period_end) begin
        act_nxt = 1'b0;
      end
    end else if (clr_req) begin
      act_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
    end
  end

  // Pins of disabled pairs pass through untouched
  assign fv = ctrl_r.ov;

  always_comb begin
    pwm_out = pwm_in;
    for (int p = 0; p < 3; p++) begin
      if (act_r && ctrl_r.en[p]) begin
        pwm_out.high[p] = fv[2*p+1];
        pwm_out.low[p]  = fv[2*p];
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/pfbo_fault_src.sv
/* Fault source and period boundary stand-in; runs on hclk. */
`timescale 1ns/1ps
`default_nettype none
module pfbo_fault_src (
  input  wire logic hclk,        // Clock
  input  wire logic trip,        // Fault request
  output logic      fault_b_pin, // Fault level
  output logic      period_end   // Boundary pulse
);
  logic [3:0] cnt = 4'h0;
  always @(posedge hclk) begin
    cnt <= cnt + 4'h1;
    period_end <= &cnt; // One boundary every 16 cycles
    fault_b_pin <= trip;
  end
endmodule
`default_nettype wire

// file: tb/pfbo_sva.sv
/* Port checker; bound to pfbo_top. */
`timescale 1ns/1ps
`default_nettype none
module pfbo_sva
  import pfbo_pkg::*;
(
  input wire logic        hclk,        // Clock
  input wire logic        hresetn,     // Reset, active low
  input wire logic        hsel,        // Slave select
  input wire logic        hwrite,      // Write
  input wire logic        hreadyout,   // Slave ready
  input wire logic        hresp,       // Response
  input wire logic        fault_b_pin, // Fault pin
  input wire logic [1:0]  htrans,      // Transfer type
  input wire logic [31:0] haddr,       // Address
  input wire logic [31:0] hrdata,      // Read data
  input wire pfbo_pins_s  pwm_in,      // Generated levels
  input wire pfbo_pins_s  pwm_out      // Pin levels
);
  logic seen;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) seen <= 1'b0;
    else if (fault_b_pin) seen <= 1'b1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_zero; hsel && htrans[1] && !hwrite && haddr == 32'h0
    |=> hrdata[15:14] == 2'h0 && hrdata[6:3] == 4'h0; endproperty
  a_zero: assert property (p_zero) else $error("reserved bits set");
  property p_pass; !seen && !fault_b_pin |-> pwm_out == pwm_in; endproperty
  a_pass: assert property (p_pass) else $error("override, no fault");
  property p_ok; !hresp; endproperty
  a_ok: assert property (p_ok) else $error("error response");
  property p_rdy; hreadyout; endproperty
  a_rdy: assert property (p_rdy) else $error("wait state");
  property p_upper; hsel && htrans[1] && !hwrite
    |=> hrdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_unmap; hsel && htrans[1] && !hwrite && haddr == 32'h10
    |=> hrdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule
bind pfbo_top pfbo_sva pfbo_sva_i(.*);
`default_nettype wire

// file: tb/testbench.sv
/* Bench for pfbo_top; needs pfbo_pkg and pfbo_fault_src. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pfbo_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lock_pin = 0, trip = 0;
  logic fault_b_pin, period_end, hreadyout, hresp, rd_ph = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h2B;
  pfbo_pins_s pwm_in = '0, pwm_out;
  logic [15:0] q[$];
  int mismatches = 0, comparisons = 0;
  pfbo_top pfbo_top_i(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .lock_pin, .fault_b_pin, .period_end, .pwm_in, .pwm_out);
  pfbo_fault_src pfbo_fault_src_i(.hclk, .trip, .fault_b_pin, .period_end);
  initial forever #2.5 hclk = ~hclk;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic pfbo_pins_s ex(logic [15:0] c, logic a);
    ex = pwm_in;
    for (int p = 0; p < 3; p++)
      if (a && c[p]) begin
        ex.high[p] = c[9+2*p];
        ex.low[p] = c[8+2*p];
      end
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    comparisons++;
    if (e !== s) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    if (!w) q.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic pchk(logic [15:0] c, logic a);
    @(negedge hclk);
    chk("pwm_out", {10'h0, ex(c, a)}, {10'h0, pwm_out});
    @(posedge hclk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    seed <= xs(seed);
    pwm_in <= seed[5:0];
    if (rd_ph) chk("hrdata", q.pop_front(), hrdata[15:0]);
    rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (3000) @(posedge hclk);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, PFBO_CTRL_OFS, 16'h0007);
    bus(1, PFBO_CTRL_OFS, 16'hFFFF);
    bus(0, PFBO_CTRL_OFS, 16'h3F87);
    bus(0, 8'h10, 16'h0000);
    lock_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    bus(1, PFBO_CTRL_OFS, 16'h0000);
    bus(0, PFBO_CTRL_OFS, 16'h3F87);
    bus(1, PFBO_KEY_OFS, PFBO_KEY_FIRST);
    bus(1, PFBO_KEY_OFS, PFBO_KEY_SECOND);
    bus(0, PFBO_STAT_OFS, 16'h000C);
    bus(1, PFBO_CTRL_OFS, 16'h0A81);
    bus(0, PFBO_CTRL_OFS, 16'h0A81);
    trip <= 1'b1;
    repeat (5) @(posedge hclk);
    pchk(16'h0A81, 1'b1);
    trip <= 1'b0;
    repeat (24) @(posedge hclk);
    pchk(16'h0A81, 1'b0);
    lock_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    bus(1, PFBO_CTRL_OFS, 16'h3F07);
    trip <= 1'b1;
    repeat (5) @(posedge hclk);
    trip <= 1'b0;
    repeat (24) @(posedge hclk);
    pchk(16'h3F07, 1'b1);
    bus(1, PFBO_CLR_OFS, 16'h0001);
    repeat (2) @(posedge hclk);
    pchk(16'h3F07, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
